/* File: src/hpf_framer.v */
// Handshake parameter field framer and remote-end start sequencer
//
// Notes on behaviour
// - MS selecting standard sets level-1 bit
// - Set level-1 bit implies level-2 field present
// - MS diagnostics bit is CL OR CLR
// - MS diagnostics bit picks diagnostics or initialization
// - MS short bit is CL AND CLR
// - MS short bit permits or forbids short init
// - MS level-2 bits zero, no level-3 blocks
// - Power-up or re-entry goes to silent state
// - Only host command leaves silent for tones
// - Handshake ending selected goes to quiet state
// - Advertising CLR sets a level-1 bit
// - CLR diagnostics bit follows local request
// - CLR short bit follows local support
// - CLR upstream blocks share CL layout
// - CLR downstream blocks absent, presence bits zero
// - CLR image block shares CL coding
// - MP fields identical to MS fields
// - Low tones bit only for ISDN options
// - Image octet holds n and type
// - Bounds block is six octets, 9-bit levels
`timescale 1ns/1ns
`default_nettype none
`include "hpf_defs.vh"

module hpf_framer #(
   parameter ADDR_W = 32
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg [3:0] hs_state,
   output reg diag_mode,
   output reg normal_init,
   output reg short_init_ok
);

   // One-hot handshake states
   // Any other code is illegal and falls back to silence
   localparam [3:0] ST_SIL = 4'h1;
   localparam [3:0] ST_TRQ = 4'h2;
   localparam [3:0] ST_QT1 = 4'h4;
   localparam [3:0] ST_OTH = 4'h8;

   // Two octets of a 9-bit level: high 3 bits, then low 6
   function [15:0] hpf_lvl;
      input [8:0] v;
      begin
         hpf_lvl = {5'h00, v[8:6], 2'h0, v[5:0]};
      end
   endfunction

   // Write data phase aimed at one register word
   function hpf_wr_hit;
      input pend;
      input [5:0] idx;
      input [5:0] want;
      begin
         hpf_wr_hit = pend & (idx == want);
      end
   endfunction

   // Low-tones bit; meaningless outside ISDN service options,
   // so both message builders clear it there
   function hpf_tones;
      input [31:0] c;
      begin
         hpf_tones = c[`HPF_F_TONES] & c[`HPF_F_ISDN];
      end
   endfunction

   // Bus capture of the pending data phase
   reg wr_pend_q; // Write data phase in progress
   reg rd_pend_q; // Read data phase, one wait state
   reg [5:0] addr_q; // Word index of the pending access

   // Software-owned registers
   reg [31:0] cfg_q; // Local capabilities and block contents
   reg [26:0] bnd_q; // Nominal, max nominal, max aggregate levels
   reg cl_diag_q; // Diagnostics bit of last peer CL
   reg cl_short_q; // Short-init bit of last peer CL
   reg cl_vld_q; // A peer CL has been recorded
   reg clr_diag_q; // Diagnostics bit of last sent CLR
   reg clr_short_q; // Short-init bit of last sent CLR
   reg clr_vld_q; // A CLR has been sent

   // Command strobes decoded from a control write
   // A strobe lasts the single write data phase cycle
   wire ctl_wr;
   wire [31:0] cmd;
   wire acc;

   // Built message fields
   // All of these are pure decode of the stored registers
   wire [7:0] img_oct;
   wire [31:0] clr_word;
   wire [31:0] ms_word;
   wire ms_spar1;
   wire ms_diag;
   wire ms_short;
   wire ms_tones;
   wire [47:0] bnd_blk;
   reg [31:0] rd_mux;

   // New access accepted in its address phase
   assign acc = hsel & hready & htrans[1];

   // Commands act in the write data phase
   assign ctl_wr = hpf_wr_hit(wr_pend_q, addr_q, `HPF_CTRL);
   assign cmd = ctl_wr ? hwdata : 32'h0000_0000;

   // Image octet: n in bits 5..2, type in bits 1..0
   assign img_oct = {2'h0, cfg_q[`HPF_F_IMGN_LO+3:`HPF_F_IMGN_LO],
                     cfg_q[`HPF_F_IMGT_LO+1:`HPF_F_IMGT_LO]};

   // Six octet bounds block, same coder as the CL block
   assign bnd_blk = {hpf_lvl(bnd_q[8:0]),
                     hpf_lvl(bnd_q[17:9]),
                     hpf_lvl(bnd_q[26:18])};

   // CLR fields; the level-2 field exists with the level-1 bit
   assign clr_word = {
      8'h00,
      img_oct,
      6'h00,
      cfg_q[`HPF_F_IMG],
      1'b0,
      1'b0,
      cfg_q[`HPF_F_USSHP],
      cfg_q[`HPF_F_USBND],
      cfg_q[`HPF_F_SHORT],
      cfg_q[`HPF_F_DIAG],
      hpf_tones(cfg_q),
      cfg_q[`HPF_F_ADV],
      cfg_q[`HPF_F_ADV]
   };

   // MS selection needs both capability exchanges seen
   // Diagnostics and short bits use the stored values even before
   // both exchanges are seen; the selection bit shows validity.
   assign ms_spar1 = cl_vld_q & clr_vld_q & cfg_q[`HPF_F_ADV];
   assign ms_diag = cl_diag_q | clr_diag_q;
   assign ms_short = cl_short_q & clr_short_q;
   // Tones bit has no meaning outside ISDN options
   assign ms_tones = hpf_tones(cfg_q);

   // MS fields: level-2 bits and level-3 count all zero
   assign ms_word = {
      16'h0000,
      4'h0,
      3'h0,
      4'h0,
      ms_short,
      ms_diag,
      ms_tones,
      ms_spar1,
      ms_spar1
   };

   // Read decode; unmapped words read zero
   // Decoded from the registered word index, so the mux has a whole
   // cycle before the data register loads
   always @* begin
      rd_mux = 32'h0000_0000;
      case (addr_q)
         `HPF_CFG: begin
            rd_mux = cfg_q;
         end
         `HPF_RXCL: begin
            rd_mux = {30'h0, cl_short_q, cl_diag_q};
         end
         `HPF_STAT: begin
            rd_mux = {23'h0, clr_vld_q, cl_vld_q, short_init_ok,
                      normal_init, diag_mode, hs_state};
         end
         `HPF_CLR: begin
            rd_mux = clr_word;
         end
         `HPF_MS: begin
            rd_mux = ms_word;
         end
         // MP reuses the MS builder so the two cannot drift apart
         `HPF_MP: begin
            rd_mux = ms_word;
         end
         `HPF_BND: begin
            rd_mux = {5'h00, bnd_q};
         end
         `HPF_BNDA: begin
            rd_mux = bnd_blk[47:16];
         end
         `HPF_BNDB: begin
            rd_mux = {8'h00, `HPF_BND_LEN, bnd_blk[15:0]};
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Bus phase tracking; reads take one wait state so any
   // write just before them has landed before data is sampled
   // Writes finish with no wait state: the data phase edge is the
   // edge at which the register loads, so nothing waits on them.
   // The transfer size is not looked at; every register is one
   // whole word and narrower writes still load the full word.
   // The response is always okay: unmapped words simply read zero
   // and swallow writes, so no access waits longer than the one read wait state.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 6'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_q) begin
            // Second cycle of a read: present data
            hrdata <= rd_mux;
            hreadyout <= 1'b1;
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
         end else if (acc) begin
            // New address phase: capture index, reads stall one cycle
            addr_q <= haddr[7:2];
            wr_pend_q <= hwrite;
            rd_pend_q <= ~hwrite;
            hreadyout <= hwrite;
         end else begin
            // Idle or deselected: nothing pending
            wr_pend_q <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   // Configuration and bounds registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= `HPF_CFG_RST;
         bnd_q <= 27'h000_0000;
      end else begin
         // Bits above the field map are dropped so they always read zero
         if (hpf_wr_hit(wr_pend_q, addr_q, `HPF_CFG)) begin
            cfg_q <= hwdata & `HPF_CFG_MASK;
         end
         // Three 9-bit levels, kept raw; the octet coder works on reads
         if (hpf_wr_hit(wr_pend_q, addr_q, `HPF_BND)) begin
            bnd_q <= hwdata[26:0];
         end
      end
   end

   // Exchange memory: peer CL bits written by software,
   // CLR bits frozen at the moment the CLR goes out
   // Freezing the CLR bits matters: software may edit its request
   // after the CLR left, but the MS must follow what the peer saw.
   // Nothing clears the valid flags except reset, so a new session
   // simply overwrites the stored bits with the latest exchange.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cl_diag_q <= 1'b0;
         cl_short_q <= 1'b0;
         cl_vld_q <= 1'b0;
         clr_diag_q <= 1'b0;
         clr_short_q <= 1'b0;
         clr_vld_q <= 1'b0;
      end else begin
         if (hpf_wr_hit(wr_pend_q, addr_q, `HPF_RXCL)) begin
            cl_diag_q <= hwdata[`HPF_X_DIAG];
            cl_short_q <= hwdata[`HPF_X_SHORT];
            cl_vld_q <= 1'b1;
         end
         if (cmd[`HPF_C_CLR_SENT]) begin
            clr_diag_q <= cfg_q[`HPF_F_DIAG];
            clr_short_q <= cfg_q[`HPF_F_SHORT];
            clr_vld_q <= 1'b1;
         end
      end
   end

   // Remote-end start sequencer; re-entry beats any other command
   // Silent: nothing on the line until the host says start.
   // Tones request: handshake under way; the host reports its end.
   // First quiet: this standard won; mode flags hold the MS outcome.
   // Other: the handshake chose some other mode of operation.
   // The mode flags are latched at the end so that later edits of
   // the exchange memory cannot change a training already begun.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hs_state <= ST_SIL;
         diag_mode <= 1'b0;
         normal_init <= 1'b0;
         short_init_ok <= 1'b0;
      end else begin
         case (hs_state)
            ST_SIL: begin
               // Only the host leaves silence
               if (cmd[`HPF_C_START] && !cmd[`HPF_C_REENTER]) begin
                  hs_state <= ST_TRQ;
               end
            end
            ST_TRQ: begin
               // Re-entry first, then end selected, then end other
               if (cmd[`HPF_C_REENTER]) begin
                  hs_state <= ST_SIL;
               end else if (cmd[`HPF_C_END_SEL]) begin
                  hs_state <= ST_QT1;
                  diag_mode <= ms_diag;
                  normal_init <= ~ms_diag;
                  short_init_ok <= ms_short;
               end else if (cmd[`HPF_C_END_OTH]) begin
                  hs_state <= ST_OTH;
               end
            end
            ST_QT1, ST_OTH: begin
               // Stay put until the host asks for a new handshake
               if (cmd[`HPF_C_REENTER]) begin
                  hs_state <= ST_SIL;
                  diag_mode <= 1'b0;
                  normal_init <= 1'b0;
                  short_init_ok <= 1'b0;
               end
            end
            default: begin
               // Illegal code falls back to silence
               hs_state <= ST_SIL;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: src/hpf_defs.vh */
// Offsets, field positions, reset values and block sizes for the parameter framer
`ifndef HPF_DEFS_VH
`define HPF_DEFS_VH

// Register word indexes, matched against address bits 7..2
`define HPF_CTRL 6'h00
`define HPF_CFG 6'h01
`define HPF_RXCL 6'h02
`define HPF_STAT 6'h03
`define HPF_CLR 6'h04
`define HPF_MS 6'h05
`define HPF_MP 6'h06
`define HPF_BND 6'h07
`define HPF_BNDA 6'h08
`define HPF_BNDB 6'h09

// Command bits, write one to act
`define HPF_C_START 0
`define HPF_C_REENTER 1
`define HPF_C_END_SEL 2
`define HPF_C_END_OTH 3
`define HPF_C_CLR_SENT 4

// Configuration fields
`define HPF_F_ADV 0
`define HPF_F_DIAG 1
`define HPF_F_SHORT 2
`define HPF_F_ISDN 3
`define HPF_F_TONES 4
`define HPF_F_USBND 5
`define HPF_F_USSHP 6
`define HPF_F_IMG 7
`define HPF_F_IMGN_LO 8
`define HPF_F_IMGT_LO 12
`define HPF_CFG_MASK 32'h0000_3FFF
`define HPF_CFG_RST 32'h0000_0000

// Peer CL capture fields
`define HPF_X_DIAG 0
`define HPF_X_SHORT 1

// Image type codes
`define HPF_IMG_OTHER 2'h0
`define HPF_IMG_CONJ 2'h1
`define HPF_IMG_ZERO 2'h2

// Block lengths in octets
`define HPF_BND_LEN 8'h06
`define HPF_IMG_LEN 8'h01

`endif

/* File: tb/hpf_checker.sv */
// Port checks for the parameter framer
`timescale 1ns/1ns
`default_nettype none
module hpf_checker #(
   parameter ADDR_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [3:0] hs_state,
   input wire logic diag_mode,
   input wire logic normal_init,
   input wire logic short_init_ok
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic cmd_q; // High in the data phase of a command write
   // Tracks command writes so state moves can be tied to their cause
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cmd_q <= 1'b0;
      else if (hready)
         cmd_q <= hsel && htrans[1] && hwrite && haddr[7:2] == 6'h00;
   end
   state_onehot_a: assert property ($onehot(hs_state)) else $error("state code bad");
   start_cause_a: assert property ($rose(hs_state == 4'h2) |->
      $past(cmd_q && hwdata[0])) else $error("tones without start");
   quiet_cause_a: assert property ($rose(hs_state == 4'h4) |->
      $past(hs_state == 4'h2 && cmd_q && hwdata[2])) else $error("quiet without end");
   reenter_silent_a: assert property (cmd_q && hwdata[1] |=> hs_state == 4'h1 &&
      !diag_mode && !normal_init && !short_init_ok) else $error("reentry missed");
   mode_pick_a: assert property (hs_state == 4'h4 |-> diag_mode != normal_init)
      else $error("mode flags bad");
   status_hold_a: assert property (!cmd_q |=>
      $stable({hs_state, diag_mode, normal_init, short_init_ok})) else $error("status moved");
   read_wait_a: assert property (hsel && htrans[1] && !hwrite && hready |=>
      !hreadyout ##1 hreadyout) else $error("read wait bad");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
endmodule
`default_nettype wire

/* File: tb/hpf_peer.sv */
// Peer model offering random CL diagnostics and short bits
`timescale 1ns/1ns
`default_nettype none
module hpf_peer (
   input wire logic hclk,
   output var logic [1:0] cl_bits
);
   integer pseed = 68; // Fixed so every run repeats
   // Fresh pair each cycle; the bench picks one when it builds a CL
   always @(posedge hclk) begin
      cl_bits <= 2'($random(pseed));
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the parameter framer
`timescale 1ns/1ns
`default_nettype none
`include "hpf_defs.vh"
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   wire [31:0] hrdata;
   wire [3:0] hs_state;
   wire [1:0] cl_bits;
   wire hready, hresp, diag_mode, normal_init, short_init_ok;
   integer seed = 68;
   integer n_mismatch = 0;
   integer num_checks = 0;
   integer i;
   logic [31:0] rd, cfg, ms, bnd;
   logic cld, cls;
   logic [2:0] exp_m; // Expected diag, normal, short flags
   logic [31:0] exp_w; // Expected status word
   always #50 hclk = ~hclk;
   hpf_framer dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .hs_state, .diag_mode,
      .normal_init, .short_init_ok);
   hpf_peer peer (.hclk, .cl_bits);
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single transfer; waits on hready in both phases
   task bus(input [5:0] idx, input w, input [31:0] d);
      haddr <= {24'h00_0000, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      rd = hrdata;
   endtask
   // Lets the write edge land before looking at the state
   task look(input [3:0] e);
      #1;
      chk("state", {28'h000_0000, hs_state}, {28'h000_0000, e});
   endtask
   function [31:0] clr_exp(input [31:0] c);
      clr_exp = {10'h000, c[11:8], c[13:12], 6'h00, c[7], 2'h0, c[6:5], c[2:1],
         c[4] & c[3], c[0], c[0]};
   endfunction
   function [15:0] oct2(input [8:0] v);
      oct2 = {5'h00, v[8:6], 2'h0, v[5:0]};
   endfunction
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      look(4'h1);
      bus(6'h0F, 1, 32'hFFFF_FFFF);
      bus(6'h0F, 0, 0);
      chk("unmapped", rd, 32'h0000_0000);
      bus(`HPF_CTRL, 1, 32'h0000_0004);
      look(4'h1);
      bus(`HPF_CTRL, 1, 32'h0000_0003);
      look(4'h1);
      for (i = 0; i < 12; i = i + 1) begin
         cfg = (i < 2) ? {32{i[0]}} & `HPF_CFG_MASK : $random(seed) & `HPF_CFG_MASK;
         {cls, cld} = cl_bits;
         bus(`HPF_CFG, 1, cfg);
         bus(`HPF_CFG, 0, 0);
         chk("cfg", rd, cfg);
         bus(`HPF_CTRL, 1, 32'h0000_0010);
         bus(`HPF_RXCL, 1, {30'h0000_0000, cls, cld});
         bus(`HPF_RXCL, 0, 0);
         chk("rxcl", rd, {30'h0000_0000, cls, cld});
         bus(`HPF_CLR, 0, 0);
         chk("clr", rd, clr_exp(cfg));
         ms = {27'h000_0000, cfg[2] & cls, cfg[1] | cld, cfg[4] & cfg[3], cfg[0], cfg[0]};
         bus(`HPF_MS, 0, 0);
         chk("ms", rd, ms);
         bus(`HPF_MP, 0, 0);
         chk("mp", rd, ms);
         bus(`HPF_CTRL, 1, 32'h0000_0002);
         look(4'h1);
         bus(`HPF_CTRL, 1, 32'h0000_0001);
         look(4'h2);
         bus(`HPF_CTRL, 1, i[0] ? 32'h0000_0008 : 32'h0000_0004);
         look(i[0] ? 4'h8 : 4'h4);
         // Flags carry the MS outcome only after ending in this standard
         exp_m = i[0] ? 3'h0 : {ms[3], ~ms[3], ms[4]};
         chk("mode", {diag_mode, normal_init, short_init_ok}, exp_m);
         exp_w = {23'h00_0000, 2'h3, exp_m[0], exp_m[1], exp_m[2], (i[0] ? 4'h8 : 4'h4)};
         bus(`HPF_STAT, 0, 0);
         chk("stat", rd, exp_w);
         bnd = $random(seed);
         bus(`HPF_BND, 1, bnd);
         bus(`HPF_BND, 0, 0);
         chk("bnd", rd, {5'h00, bnd[26:0]});
         bus(`HPF_BNDA, 0, 0);
         chk("bnda", rd, {oct2(bnd[8:0]), oct2(bnd[17:9])});
         bus(`HPF_BNDB, 0, 0);
         chk("bndb", rd, {8'h00, `HPF_BND_LEN, oct2(bnd[26:18])});
      end
      // Reset in mid-run: state, flags and exchange memory start over
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      look(4'h1);
      chk("flags", {diag_mode, normal_init, short_init_ok}, 3'h0);
      bus(`HPF_MS, 0, 0);
      chk("ms reset", rd, 32'h0000_0000);
      stop_test;
   end
endmodule
bind hpf_framer hpf_checker #(.ADDR_W(ADDR_W)) u_check (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .hs_state,
   .diag_mode, .normal_init, .short_init_ok);
`default_nettype wire
